// *** hdl/line_rx_pkg.sv ***
package line_rx_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATE_OFS = 8'h04;
    localparam logic [7:0] INT_STATUS_OFS = 8'h08;
    localparam logic [7:0] INT_MASK_OFS = 8'h0c;
    // Control fields
    localparam int CTRL_RAIL_EN_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    // State fields
    localparam int ST_LOS_BIT = 0;
    localparam int ST_LOL_BIT = 1;
    localparam int ST_ANA_LOS_BIT = 2;
    localparam int ST_DIG_LOS_BIT = 3;
    localparam int ST_THR_LSB = 4;
    // Interrupt events, same layout in status and mask
    localparam int EV_LOS_SET = 0;
    localparam int EV_LOL_SET = 1;
    localparam int EV_LOS_CLR = 2;
    localparam int EV_LOL_CLR = 3;
    localparam int EV_W = 4;
    localparam logic [EV_W-1:0] INT_MASK_RESET = 4'h0;
    // Alarm timing in recovered clock cycles
    localparam int ALARM_MIN_CYCLES = 32;
    localparam int ZERO_RUN_SET = 160;
    localparam int ONES_WINDOW = 32;
    localparam int ONES_CLEAR = 10;
    // Frequency comparison: window in reference cycles, limit per mille
    localparam int FREQ_WINDOW = 1024;
    localparam int FREQ_LIMIT_PERMIL = 5;
    localparam int FREQ_TOL = FREQ_WINDOW * FREQ_LIMIT_PERMIL / 1000;
    localparam int NO_DATA_BITS = 250;
    // Threshold select strap and code sent to the amplitude detector
    typedef enum logic [1:0] {
        THR_HIGHEST = 2'b00,
        THR_MIDDLE = 2'b01,
        THR_LOWEST = 2'b10
    } los_thr_t;
    typedef enum logic {
        LOCK_OK,
        LOCK_HUNT
    } lock_state_t;
    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] HTRANS_SEQ = 2'b11;
endpackage

// *** hdl/edge_sync.sv ***
`timescale 1ns/1ns
module edge_sync
    import line_rx_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Asynchronous level and its synchronised view
    input wire logic async_in,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    // First stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign rise = sync_r & ~last_r;
    assign fall = ~sync_r & last_r;
endmodule

// *** hdl/min_pulse_hold.sv ***
`timescale 1ns/1ns
module min_pulse_hold
    import line_rx_pkg::*;
#(
    parameter int MIN_TICKS = ALARM_MIN_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Counting enable and raw alarm
    input wire logic tick,
    input wire logic req,
    // Alarm held for at least MIN_TICKS ticks
    output logic hold_out
);
    localparam int CW = $clog2(MIN_TICKS + 1);
    localparam logic [CW-1:0] LOAD = CW'(MIN_TICKS);
    logic [CW-1:0] cnt_r;
    logic out_r;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            out_r <= 1'b0;
            cnt_r <= '0;
        end else if (req && !out_r) begin
            out_r <= 1'b1;
            cnt_r <= LOAD;
        end else if (out_r) begin
            if (tick && cnt_r != '0)
                cnt_r <= cnt_r - 1'b1;
            if (!req && cnt_r == '0)
                out_r <= 1'b0;
        end
    end

    assign hold_out = out_r;
endmodule

// *** hdl/line_receiver.sv ***
`timescale 1ns/1ns
module line_receiver
    import line_rx_pkg::*;
#(
    parameter int WINDOW = FREQ_WINDOW
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Analog front end and pins
    input wire logic recovered_clock_in,
    input wire logic reference_clock_in,
    input wire logic pos_pulse_in,
    input wire logic neg_pulse_in,
    input wire logic analog_los_in,
    input wire logic [1:0] los_threshold_select,
    input wire logic test_tristate_n,
    // Threshold code to the amplitude detector
    output logic [1:0] los_threshold_code,
    // System side outputs with enables
    output logic recovered_clock_out,
    output logic recovered_clock_oe,
    output logic positive_rail_data,
    output logic positive_rail_oe,
    output logic negative_rail_data,
    output logic negative_rail_oe,
    output logic signal_loss_alarm,
    output logic signal_loss_oe,
    output logic lock_loss_alarm,
    output logic lock_loss_oe,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Interrupt
    output logic irq
);
    localparam int FW = $clog2(2 * WINDOW + 1);
    localparam logic [FW-1:0] WIN_LAST = FW'(WINDOW - 1);
    localparam logic [FW-1:0] TOL = FW'(WINDOW * FREQ_LIMIT_PERMIL / 1000);
    localparam logic [FW-1:0] SAT = {FW{1'b1}};
    localparam logic [7:0] ZRUN_SET = 8'(ZERO_RUN_SET);
    localparam logic [5:0] ONES_MIN = 6'(ONES_CLEAR);

    logic rclk_lvl, rclk_rise;
    logic ref_rise;
    logic pos_lvl, neg_lvl, ana_lvl, ict_lvl;
    logic [1:0] strap_lvl;

    edge_sync u_rclk (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .async_in(recovered_clock_in), .level(rclk_lvl),
        .rise(rclk_rise), .fall());
    edge_sync u_ref (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .async_in(reference_clock_in), .level(), .rise(ref_rise), .fall());
    edge_sync u_pos (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .async_in(pos_pulse_in), .level(pos_lvl), .rise(), .fall());
    edge_sync u_neg (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .async_in(neg_pulse_in), .level(neg_lvl), .rise(), .fall());
    edge_sync u_ana (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .async_in(analog_los_in), .level(ana_lvl), .rise(), .fall());
    edge_sync u_ict (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .async_in(test_tristate_n), .level(ict_lvl), .rise(), .fall());
    edge_sync u_st0 (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .async_in(los_threshold_select[0]), .level(strap_lvl[0]),
        .rise(), .fall());
    edge_sync u_st1 (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .async_in(los_threshold_select[1]), .level(strap_lvl[1]),
        .rise(), .fall());

    // Threshold strap: caught once after reset, later changes ignored.
    // The strap synchronisers restart with reset, so capture waits two
    // cycles until they show the pin again.
    logic strap_taken_r;
    logic [1:0] strap_wait_r;
    logic [1:0] thr_r;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            strap_taken_r <= 1'b0;
            strap_wait_r <= 2'b00;
            thr_r <= THR_MIDDLE;
        end else if (!strap_wait_r[1]) begin
            strap_wait_r <= {strap_wait_r[0], 1'b1};
        end else if (!strap_taken_r) begin
            strap_taken_r <= 1'b1;
            unique case (strap_lvl)
                2'b11: thr_r <= THR_LOWEST;
                2'b00: thr_r <= THR_HIGHEST;
                default: thr_r <= THR_MIDDLE;
            endcase
        end
    end

    // Frequency comparison over a window of reference cycles
    logic [FW-1:0] ref_cnt_r, rec_cnt_r;
    logic freq_bad_r;
    logic [FW-1:0] diff;
    always_comb begin
        if (rec_cnt_r > WIN_LAST + 1'b1)
            diff = rec_cnt_r - WIN_LAST - 1'b1;
        else
            diff = WIN_LAST + 1'b1 - rec_cnt_r;
    end

    // Window of 1024 reference cycles exceeds 250 bit periods, so drift
    // after data loss cannot flag before then
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ref_cnt_r <= '0;
            rec_cnt_r <= '0;
            freq_bad_r <= 1'b0;
        end else begin
            if (ref_rise && ref_cnt_r == WIN_LAST) begin
                ref_cnt_r <= '0;
                rec_cnt_r <= {{(FW-1){1'b0}}, rclk_rise};
                freq_bad_r <= diff > TOL;
            end else begin
                if (ref_rise)
                    ref_cnt_r <= ref_cnt_r + 1'b1;
                if (rclk_rise && rec_cnt_r != SAT)
                    rec_cnt_r <= rec_cnt_r + 1'b1;
            end
        end
    end

    // Lock hunting state
    lock_state_t lock_st_r;
    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            lock_st_r <= LOCK_OK;
        else begin
            unique case (lock_st_r)
                LOCK_OK: if (freq_bad_r) lock_st_r <= LOCK_HUNT;
                LOCK_HUNT: if (!freq_bad_r) lock_st_r <= LOCK_OK;
            endcase
        end
    end

    logic lol_held;
    min_pulse_hold #(.MIN_TICKS(ALARM_MIN_CYCLES)) u_lol_hold (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .tick(rclk_rise),
        .req(lock_st_r == LOCK_HUNT), .hold_out(lol_held));

    // Digital loss of signal: zero run and ones density over 32 bits
    logic [7:0] zrun_r;
    logic [ONES_WINDOW-1:0] bits_r;
    logic [5:0] ones_r;
    logic dig_raw_r;
    logic cur_bit;
    logic [5:0] ones_nxt;
    assign cur_bit = pos_lvl | neg_lvl;
    always_comb begin
        ones_nxt = ones_r + {5'b0, cur_bit} - {5'b0, bits_r[ONES_WINDOW-1]};
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            zrun_r <= '0;
            bits_r <= '0;
            ones_r <= '0;
            dig_raw_r <= 1'b0;
        end else if (rclk_rise) begin
            bits_r <= {bits_r[ONES_WINDOW-2:0], cur_bit};
            ones_r <= ones_nxt;
            if (cur_bit)
                zrun_r <= '0;
            else if (zrun_r != ZRUN_SET)
                zrun_r <= zrun_r + 1'b1;
            if (!cur_bit && zrun_r == ZRUN_SET - 1'b1)
                dig_raw_r <= 1'b1;
            else if (dig_raw_r && ones_nxt >= ONES_MIN)
                dig_raw_r <= 1'b0;
        end
    end

    logic dig_held, ana_held;
    min_pulse_hold #(.MIN_TICKS(ALARM_MIN_CYCLES)) u_dig_hold (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .tick(rclk_rise),
        .req(dig_raw_r), .hold_out(dig_held));
    min_pulse_hold #(.MIN_TICKS(ALARM_MIN_CYCLES)) u_ana_hold (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .tick(rclk_rise),
        .req(ana_lvl), .hold_out(ana_held));

    // Control register
    logic rail_en_r;

    // Output pins; clock out is the synchronised level so rails change
    // on the same edge as its rise
    logic rclk_out_r, pos_r, neg_r, los_r, lol_r, oe_r;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rclk_out_r <= 1'b0;
            pos_r <= 1'b0;
            neg_r <= 1'b0;
            los_r <= 1'b0;
            lol_r <= 1'b0;
            oe_r <= 1'b0;
        end else begin
            rclk_out_r <= rclk_lvl;
            if (rclk_rise) begin
                pos_r <= rail_en_r & pos_lvl & ~neg_lvl;
                neg_r <= rail_en_r & neg_lvl & ~pos_lvl;
            end
            los_r <= ana_held | dig_held;
            lol_r <= lol_held;
            oe_r <= ict_lvl;
        end
    end

    // Bus slave: zero wait state, read data captured in address phase
    logic [EV_W-1:0] int_stat_r, int_mask_r;
    logic [31:0] rdata_r;
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic irq_r;
    logic acc;
    logic [31:0] state_word;
    logic [EV_W-1:0] ev;
    logic los_prev_r, lol_prev_r;

    assign acc = hsel && hready && (htrans == HTRANS_NONSEQ ||
        htrans == HTRANS_SEQ);
    always_comb begin
        state_word = '0;
        state_word[ST_LOS_BIT] = los_r;
        state_word[ST_LOL_BIT] = lol_r;
        state_word[ST_ANA_LOS_BIT] = ana_held;
        state_word[ST_DIG_LOS_BIT] = dig_held;
        state_word[ST_THR_LSB +: 2] = thr_r;
    end

    always_comb begin
        ev = '0;
        ev[EV_LOS_SET] = los_r & ~los_prev_r;
        ev[EV_LOL_SET] = lol_r & ~lol_prev_r;
        ev[EV_LOS_CLR] = ~los_r & los_prev_r;
        ev[EV_LOL_CLR] = ~lol_r & lol_prev_r;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdata_r <= '0;
            wr_pend_r <= 1'b0;
            wr_addr_r <= '0;
        end else begin
            wr_pend_r <= acc && hwrite;
            wr_addr_r <= haddr;
            if (acc && !hwrite) begin
                unique case (haddr)
                    CTRL_OFS: rdata_r <= {31'b0, rail_en_r};
                    STATE_OFS: rdata_r <= state_word;
                    INT_STATUS_OFS: rdata_r <= {28'b0, int_stat_r};
                    INT_MASK_OFS: rdata_r <= {28'b0, int_mask_r};
                    default: rdata_r <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rail_en_r <= CTRL_RESET[CTRL_RAIL_EN_BIT];
            int_mask_r <= INT_MASK_RESET;
        end else if (wr_pend_r) begin
            if (wr_addr_r == CTRL_OFS)
                rail_en_r <= hwdata[CTRL_RAIL_EN_BIT];
            if (wr_addr_r == INT_MASK_OFS)
                int_mask_r <= hwdata[EV_W-1:0];
        end
    end

    // Read of status clears it; a new event in that cycle survives
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            int_stat_r <= '0;
            los_prev_r <= 1'b0;
            lol_prev_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            los_prev_r <= los_r;
            lol_prev_r <= lol_r;
            if (acc && !hwrite && haddr == INT_STATUS_OFS)
                int_stat_r <= ev;
            else
                int_stat_r <= int_stat_r | ev;
            irq_r <= |(int_stat_r & int_mask_r);
        end
    end

    assign los_threshold_code = thr_r;
    assign recovered_clock_out = rclk_out_r;
    assign positive_rail_data = pos_r;
    assign negative_rail_data = neg_r;
    assign signal_loss_alarm = los_r;
    assign lock_loss_alarm = lol_r;
    assign recovered_clock_oe = oe_r;
    assign positive_rail_oe = oe_r;
    assign negative_rail_oe = oe_r;
    assign signal_loss_oe = oe_r;
    assign lock_loss_oe = oe_r;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_r;
    assign irq = irq_r;
endmodule

// *** tb/line_rx_checker.sv ***
`timescale 1ns/1ns
module line_rx_checker
    import line_rx_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Pins in
    input wire logic analog_los_in,
    input wire logic [1:0] los_threshold_select,
    input wire logic test_tristate_n,
    // Pins out
    input wire logic [1:0] los_threshold_code,
    input wire logic recovered_clock_out,
    input wire logic recovered_clock_oe,
    input wire logic positive_rail_data,
    input wire logic positive_rail_oe,
    input wire logic negative_rail_data,
    input wire logic negative_rail_oe,
    input wire logic signal_loss_alarm,
    input wire logic signal_loss_oe,
    input wire logic lock_loss_alarm,
    input wire logic lock_loss_oe
);
    logic rc_r;
    logic rise;
    logic [4:0] oes;
    logic [7:0] zrun_r;
    logic [7:0] lolw_r;
    logic [7:0] losw_r;
    assign rise = recovered_clock_out && !rc_r;
    assign oes = {recovered_clock_oe, positive_rail_oe, negative_rail_oe,
        signal_loss_oe, lock_loss_oe};
    always_ff @(posedge sys_clk) begin
        rc_r <= !sys_rst && recovered_clock_out;
    end
    // Counters saturate so a long run cannot wrap back under a limit
    always_ff @(posedge sys_clk) begin
        if (sys_rst || (rise && (positive_rail_data || negative_rail_data)))
            zrun_r <= 8'h00;
        else if (rise && zrun_r != 8'hff)
            zrun_r <= zrun_r + 8'h01;
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !lock_loss_alarm)
            lolw_r <= 8'h00;
        else if (rise && lolw_r != 8'hff)
            lolw_r <= lolw_r + 8'h01;
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !signal_loss_alarm)
            losw_r <= 8'h00;
        else if (rise && losw_r != 8'hff)
            losw_r <= losw_r + 8'h01;
    end
    function automatic logic [1:0] thr_of(input logic [1:0] s);
        if (s == 2'b11)
            return THR_LOWEST;
        return (s == 2'b00) ? THR_HIGHEST : THR_MIDDLE;
    endfunction
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    sequence s_tri_low;
        !test_tristate_n [*5];
    endsequence
    sequence s_tri_high;
        test_tristate_n [*5];
    endsequence
    a_oe_same: assert property ((&oes) == (|oes))
        else $error("output enables disagree");
    a_tri_off: assert property (s_tri_low |-> oes == 5'h00)
        else $error("outputs driven in test mode");
    a_tri_on: assert property (s_tri_high |-> oes == 5'h1f)
        else $error("outputs released in normal mode");
    a_rails_excl: assert property (
        !(positive_rail_data && negative_rail_data))
        else $error("both rails high");
    a_rails_rise: assert property ($rose(positive_rail_data) ||
        $rose(negative_rail_data) |-> $rose(recovered_clock_out))
        else $error("rail rose off the clock rise");
    a_lol_width: assert property (
        $fell(lock_loss_alarm) |-> lolw_r >= 8'h1f)
        else $error("lock alarm pulse too short");
    a_los_width: assert property (
        $fell(signal_loss_alarm) |-> losw_r >= 8'h1f)
        else $error("signal alarm pulse too short");
    a_los_or: assert property (analog_los_in [*8] |-> signal_loss_alarm)
        else $error("analog loss not on alarm");
    a_zero_run: assert property (
        zrun_r >= 8'ha2 |-> signal_loss_alarm)
        else $error("zero run not alarmed");
    a_thr_code: assert property ($stable(los_threshold_select) [*4] |->
        los_threshold_code == thr_of(los_threshold_select))
        else $error("threshold code wrong");
endmodule

bind line_receiver line_rx_checker u_chk (
    .sys_clk, .sys_rst, .analog_los_in, .los_threshold_select,
    .test_tristate_n, .los_threshold_code, .recovered_clock_out,
    .recovered_clock_oe, .positive_rail_data, .positive_rail_oe,
    .negative_rail_data, .negative_rail_oe, .signal_loss_alarm,
    .signal_loss_oe, .lock_loss_alarm, .lock_loss_oe
);

// *** tb/framer_model.sv ***
`timescale 1ns/1ns
module framer_model (
    // Clock and rails from the receiver
    input wire logic rclk,
    input wire logic rclk_oe,
    input wire logic pos_rail,
    input wire logic neg_rail,
    // Tallies of marks taken in
    output int pos_cnt,
    output int neg_cnt
);
    initial begin
        pos_cnt = 0;
        neg_cnt = 0;
    end
    // Rails move on the rise, so the fall is the safe sampling point
    // Alarms are not taken in: loss of signal is no error counter
    always @(negedge rclk) begin
        if (rclk_oe) begin
            pos_cnt <= pos_cnt + int'(pos_rail);
            neg_cnt <= neg_cnt + int'(neg_rail);
        end
    end
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
    import line_rx_pkg::*;
    logic sys_clk, sys_rst, rclk_in, ref_in, ana, tst_n;
    logic pp = 1'b0, np = 1'b0;
    logic rc_q = 1'b0;
    logic [1:0] strap, code, htrans;
    logic rco, rco_oe, prd, pr_oe, nrd, nr_oe, los, los_oe, lol, lol_oe;
    logic hsel, hwrite, hrdy, hresp, irq;
    logic [7:0] haddr;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic [1:0] straps[3] = '{2'b00, 2'b01, 2'b11};
    wire [31:0] oes = {27'h0, rco_oe, pr_oe, nr_oe, los_oe, lol_oe};
    int num_errors = 0, checks = 0, cyc = 0, seed = 32'h8c02, r, i;
    int mode = 0, ones_left = 0, sp = 0, sn = 0, fp, fn, p0, n0;
    int rc_lo = 64;
    initial begin
        sys_clk = 0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Edges kept off the system clock edges; low phase sets the rate
    initial begin
        rclk_in = 0;
        #3;
        forever begin
            rclk_in = 1;
            #61;
            rclk_in = 0;
            #rc_lo;
        end
    end
    initial begin
        ref_in = 0;
        #1;
        forever begin
            #61 ref_in = 1;
            #64 ref_in = 0;
        end
    end
    line_receiver #(.WINDOW(256)) DUT (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .recovered_clock_in(rclk_in),
        .reference_clock_in(ref_in), .pos_pulse_in(pp), .neg_pulse_in(np),
        .analog_los_in(ana), .los_threshold_select(strap),
        .test_tristate_n(tst_n), .los_threshold_code(code),
        .recovered_clock_out(rco), .recovered_clock_oe(rco_oe),
        .positive_rail_data(prd), .positive_rail_oe(pr_oe),
        .negative_rail_data(nrd), .negative_rail_oe(nr_oe),
        .signal_loss_alarm(los), .signal_loss_oe(los_oe),
        .lock_loss_alarm(lol), .lock_loss_oe(lol_oe), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(hresp),
        .hrdata(hrdata), .irq(irq)
    );
    framer_model u_fm (.rclk(rco), .rclk_oe(pr_oe), .pos_rail(prd),
        .neg_rail(nrd), .pos_cnt(fp), .neg_cnt(fn));
    // New symbol just after the link clock falls, stable at its rise
    always @(posedge sys_clk) begin
        rc_q <= rclk_in;
        r = $random(seed);
        if (rc_q && !rclk_in) begin
            if (mode == 1)
                {pp, np} <= r[1:0];
            else if (ones_left > 0) begin
                {pp, np} <= ones_left[0] ? 2'b10 : 2'b01;
                ones_left--;
            end else
                {pp, np} <= 2'b00;
        end
    end
    always @(posedge rclk_in) begin
        sp += int'(pp && !np);
        sn += int'(np && !pp);
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 60000) begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t bit %b want %b", $time, got, exp);
        end
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t word %h want %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w,
        input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        @(posedge sys_clk);
        while (hrdy !== 1'b1) @(posedge sys_clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge sys_clk);
        while (hrdy !== 1'b1) @(posedge sys_clk);
        rd = hrdata;
    endtask
    task automatic bits(input int n);
        repeat (n) @(posedge rclk_in);
        @(posedge sys_clk);
    endtask
    task automatic do_reset(input logic [1:0] s);
        strap <= s;
        sys_rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        // Strap is caught on the third edge after release
        repeat (3) @(posedge sys_clk);
    endtask
    function automatic logic [31:0] exp_state(input logic [1:0] s);
        logic [1:0] c;
        c = (s == 2'b11) ? THR_LOWEST :
            (s == 2'b00 ? THR_HIGHEST : THR_MIDDLE);
        return 32'(c) << ST_THR_LSB;
    endfunction
    task automatic pulse_analog();
        ana <= 1'b1;
        repeat (10) @(posedge sys_clk);
        ana <= 1'b0;
    endtask
    initial begin
        sys_rst = 1'b1;
        tst_n = 1'b1;
        strap = 2'b11;
        hsize = 3'h2;
        {ana, hsel, hwrite} = 3'h0;
        {haddr, htrans, hwdata} = '0;
        foreach (straps[k]) begin
            do_reset(straps[k]);
            bus(STATE_OFS, 1'b0, 32'h0);
            chk_word(rd, exp_state(straps[k]));
            chk_bit(hresp, 1'b0);
        end
        bus(CTRL_OFS, 1'b0, 32'h0);
        chk_word(rd, CTRL_RESET);
        bus(8'h10, 1'b0, 32'h0);
        chk_word(rd, 32'h0);
        $display("test strap done");
        tst_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        chk_word(oes, 32'h0);
        tst_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk_word(oes, 32'h1f);
        $display("test tristate done");
        p0 = sp - fp;
        n0 = sn - fn;
        mode = 1;
        bits(300);
        mode = 0;
        bits(4);
        chk_word(32'(sp - fp), 32'(p0));
        chk_word(32'(sn - fn), 32'(n0));
        ones_left = 40;
        bits(2);
        bus(CTRL_OFS, 1'b1, 32'h0);
        bits(3);
        chk_bit(prd | nrd, 1'b0);
        ones_left = 0;
        bits(3);
        bus(CTRL_OFS, 1'b1, CTRL_RESET);
        mode = 1;
        $display("test rails done");
        bus(INT_MASK_OFS, 1'b1, 32'h1);
        bus(INT_STATUS_OFS, 1'b0, 32'h0);
        pulse_analog();
        bits(4);
        chk_bit(irq, 1'b1);
        bits(24);
        chk_bit(los, 1'b1);
        bits(8);
        chk_bit(los, 1'b0);
        bus(INT_STATUS_OFS, 1'b0, 32'h0);
        chk_word(rd, 32'h5);
        repeat (2) @(posedge sys_clk);
        chk_bit(irq, 1'b0);
        bus(INT_MASK_OFS, 1'b1, 32'h0);
        pulse_analog();
        bits(4);
        chk_bit(irq, 1'b0);
        bits(36);
        bus(INT_STATUS_OFS, 1'b0, 32'h0);
        $display("test analog done");
        mode = 0;
        bits(150);
        chk_bit(los, 1'b0);
        bits(20);
        chk_bit(los, 1'b1);
        chk_bit(lol, 1'b0);
        bits(30);
        ones_left = 9;
        bits(13);
        chk_bit(los, 1'b1);
        ones_left = 1;
        bits(4);
        chk_bit(los, 1'b0);
        $display("test density done");
        mode = 1;
        rc_lo = 79;
        for (i = 0; i < 12000 && lol !== 1'b1; i++) @(posedge sys_clk);
        chk_bit(lol, 1'b1);
        rc_lo = 64;
        for (i = 0; i < 12000 && lol !== 1'b0; i++) @(posedge sys_clk);
        chk_bit(lol, 1'b0);
        bus(INT_STATUS_OFS, 1'b0, 32'h0);
        chk_word(rd & 32'ha, 32'ha);
        $display("test lock done");
        end_of_test();
    end
endmodule
